//--- ops_pkg.sv
// Package with constants and carrier types for the output pulse shaper
package ops_pkg;

  localparam int OPS_CNT_W = 32;
  localparam logic [31:0] OPS_DIV_RST = 32'h0000_0002;
  localparam logic [31:0] OPS_WIDTH_RST = 32'h0000_0000;
  localparam logic [31:0] OPS_ONE = 32'h0000_0001;
  localparam logic [31:0] OPS_MIN_HALF = 32'h0000_0002;
  localparam logic [31:0] OPS_MIN_PHASE_DIV = 32'h0000_0005;

  // Output shaping configuration
  typedef struct packed {
    logic [31:0] divide_ratio;
    logic [31:0] pulse_width;
    logic diff_mode;
    logic comp_invert;
  } ops_cfg_t;

  // Coarse phase request
  typedef struct packed {
    logic valid;
    logic signed [32:0] step;
  } ops_step_t;

endpackage : ops_pkg

//--- ops_pin_drive.sv
// Output buffer pin mapping for one buffer
`timescale 1ns/100ps
module ops_pin_drive
  import ops_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic shaped_i,
  input wire logic diff_mode_i,
  input wire logic comp_invert_i,
  output logic true_output_pin_o,
  output logic complementary_output_pin_o
);

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      true_output_pin_o <= 1'b0;
      complementary_output_pin_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      true_output_pin_o <= shaped_i; // [R16]
      if (diff_mode_i)
        complementary_output_pin_o <= ~shaped_i; // [R16]
      else
        complementary_output_pin_o <= comp_invert_i ? ~shaped_i : shaped_i; // [R17] [R6]
    end
  end

endmodule : ops_pin_drive

//--- ops_shaper.sv
// Output pulse shaper with coarse phase steps, driving two buffers
// Operation
// R1 - Each output period is a count of source cycles given by a 32-bit divide ratio.
// R2 - With no pulse width the output is a clock with equal high and low parts.
// R3 - A 32-bit pulse width gives the high time in source cycles, zero selects the even clock.
// R4 - Software keeps the pulse width below the divide ratio.
// R5 - A nonzero pulse width is high at the start of the period, low for the rest.
// R6 - Pulses are high-going; low-going only via the inverted complementary pin.
// R7 - Coarse phase steps act on this output alone, in whole source periods.
// R8 - A step never leaves less than two source periods high and two low.
// R9 - Software does not step an output whose divide ratio is one to four.
// R10 - One step changes a period by at most 2^32 source periods high plus the same low.
// R11 - A signed step is applied within one period; positive lengthens, negative shortens.
// R12 - In even-clock mode a step is split about equally between high and low.
// R13 - In pulse mode a step changes only the low part.
// R14 - Successive steps accumulate without bound; here each step alters one period only, then the nominal lengths return.
// R15 - Software spreads large changes over several small steps.
// R16 - Each buffer drives one differential or two single-ended signals; two buffers share the source.
// R17 - Single-ended pins carry the same clock, complementary pin optionally inverted.
`timescale 1ns/100ps
module ops_shaper
  import ops_pkg::*;
#(
  parameter int NUM_BUF = 2
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire ops_cfg_t cfg_i,
  input wire ops_step_t step_i,
  output logic step_busy_o,
  output logic phase_high_o,
  output logic [NUM_BUF-1:0] true_output_pin_o,
  output logic [NUM_BUF-1:0] complementary_output_pin_o
);

  typedef enum logic [1:0] {
    ST_HIGH = 2'b01,
    ST_LOW = 2'b10
  } ops_state_t;

  ops_state_t state_ff;
  logic [32:0] count_ff;
  logic signed [33:0] pend_lo_ff;
  logic signed [33:0] pend_hi_ff;
  logic pend_ff;
  logic shaped_ff;
  logic [32:0] high_len;
  logic [32:0] low_len;
  logic [32:0] nxt_high;
  logic [32:0] nxt_low;
  logic period_start;
  logic high_end;
  logic apply_ff;

  // Clamp a length plus a signed step to the two-cycle floor
  function automatic logic [32:0] ops_adj(input logic [32:0] base, input logic signed [33:0] delta);
    logic signed [35:0] sum;
    sum = 36'(signed'({1'b0, base})) + 36'(delta);
    if (sum < 36'(signed'({1'b0, OPS_MIN_HALF})))
      ops_adj = {1'b0, OPS_MIN_HALF}; // [R8]
    else if (sum[35:33] != 3'b000)
      ops_adj = 33'h1_FFFF_FFFF;
    else
      ops_adj = sum[32:0];
  endfunction : ops_adj

  // ----------------------------------------
  // Nominal high and low lengths
  // ----------------------------------------
  always_comb
  begin
    if (cfg_i.pulse_width == OPS_WIDTH_RST)
    begin
      high_len = {1'b0, (cfg_i.divide_ratio >> 1)}; // [R2]
      low_len = {1'b0, cfg_i.divide_ratio} - high_len; // [R1]
    end
    else
    begin
      high_len = {1'b0, cfg_i.pulse_width}; // [R3] [R5]
      low_len = {1'b0, cfg_i.divide_ratio} - {1'b0, cfg_i.pulse_width}; // [R4]
    end
    // Halves below one cycle stretch to one
    if (high_len == 33'h0_0000_0000)
      high_len = {1'b0, OPS_ONE};
    if (low_len == 33'h0_0000_0000)
      low_len = {1'b0, OPS_ONE};
    // A zero share keeps its half at the nominal length
    nxt_high = (pend_ff && pend_hi_ff != '0) ? ops_adj(high_len, pend_hi_ff) : high_len; // [R11]
    nxt_low = (apply_ff && pend_lo_ff != '0) ? ops_adj(low_len, pend_lo_ff) : low_len; // [R12] [R13]
  end

  // Last cycle of each half
  assign period_start = (state_ff == ST_LOW) && (count_ff <= {1'b0, OPS_ONE});
  assign high_end = (state_ff == ST_HIGH) && (count_ff <= {1'b0, OPS_ONE});

  // ----------------------------------------
  // Pending coarse step
  // ----------------------------------------
  // Held until the adjusted low part is loaded
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      pend_ff <= 1'b0;
      pend_hi_ff <= '0;
      pend_lo_ff <= '0;
    end
    else if (clk_en_i)
    begin
      if (step_i.valid && !pend_ff && cfg_i.divide_ratio >= OPS_MIN_PHASE_DIV) // [R7] [R9]
      begin
        pend_ff <= 1'b1;
        if (cfg_i.pulse_width == OPS_WIDTH_RST)
        begin
          pend_hi_ff <= 34'(step_i.step >>> 1); // [R12]
          pend_lo_ff <= 34'(step_i.step) - 34'(step_i.step >>> 1);
        end
        else
        begin
          pend_hi_ff <= '0; // [R13]
          pend_lo_ff <= 34'(step_i.step);
        end
      end
      else if (high_end && apply_ff)
        pend_ff <= 1'b0; // [R14]
    end
  end

  // ----------------------------------------
  // Step application window
  // ----------------------------------------
  // Set with the adjusted high part, cleared once the low part follows
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      apply_ff <= 1'b0;
    else if (clk_en_i)
    begin
      if (period_start && pend_ff)
        apply_ff <= 1'b1; // [R11]
      else if (high_end)
        apply_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Period counter and shaping state
  // ----------------------------------------
  // High part first, then the low part
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= ST_LOW;
      count_ff <= {1'b0, OPS_ONE};
      shaped_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      unique case (state_ff)
        ST_HIGH:
        begin
          if (high_end)
          begin
            state_ff <= ST_LOW;
            count_ff <= nxt_low; // [R10]
            shaped_ff <= 1'b0;
          end
          else
            count_ff <= count_ff - 33'h0_0000_0001;
        end
        ST_LOW:
        begin
          if (period_start)
          begin
            state_ff <= ST_HIGH;
            count_ff <= nxt_high; // [R1]
            shaped_ff <= 1'b1; // [R6]
          end
          else
            count_ff <= count_ff - 33'h0_0000_0001;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status flops
  // ----------------------------------------
  // Status lags the internal state by one cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      step_busy_o <= 1'b0;
      phase_high_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      step_busy_o <= pend_ff;
      phase_high_o <= shaped_ff;
    end
  end

  // ----------------------------------------
  // Output buffers
  // ----------------------------------------
  // Both buffers share the shaped source
  for (genvar g = 0; g < NUM_BUF; g++)
  begin : g_buf
    ops_pin_drive u_drive (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .shaped_i(shaped_ff),
      .diff_mode_i(cfg_i.diff_mode),
      .comp_invert_i(cfg_i.comp_invert),
      .true_output_pin_o(true_output_pin_o[g]),
      .complementary_output_pin_o(complementary_output_pin_o[g])
    );
  end

endmodule : ops_shaper

//--- ops_shaper_assertions.sv
// Port checker for the output pulse shaper
`timescale 1ns/100ps
module ops_shaper_chk
  import ops_pkg::*;
#(
  parameter int NUM_BUF = 2
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire ops_cfg_t cfg_i,
  input wire ops_step_t step_i,
  input wire logic step_busy_o,
  input wire logic phase_high_o,
  input wire logic [NUM_BUF-1:0] true_output_pin_o,
  input wire logic [NUM_BUF-1:0] complementary_output_pin_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire div_ok = cfg_i.divide_ratio >= OPS_MIN_PHASE_DIV;
  wire [1:0] tp = true_output_pin_o;
  wire [1:0] cp = complementary_output_pin_o;
  property p_buf; tp[1] == tp[0]; endproperty
  a_buf: assert property (p_buf) else $error("buffers differ");
  property p_copy; phase_high_o == tp[0]; endproperty
  a_copy: assert property (p_copy) else $error("phase copy differs");
  property p_diff; $past(reset_n_i) && $past(cfg_i.diff_mode) |-> cp == ~tp; endproperty
  a_diff: assert property (p_diff) else $error("diff pair wrong");
  property p_se; $past(reset_n_i) && !$past(cfg_i.diff_mode) |-> cp == (tp ^ {2{$past(cfg_i.comp_invert)}});
  endproperty
  a_se: assert property (p_se) else $error("single-ended pair wrong");
  property p_hi; div_ok && cfg_i.pulse_width != OPS_ONE && $fell(phase_high_o) |-> $past(phase_high_o, 2);
  endproperty
  a_hi: assert property (p_hi) else $error("high part too short");
  property p_lo; div_ok && cfg_i.divide_ratio - cfg_i.pulse_width != OPS_ONE && $rose(phase_high_o)
    |-> !$past(phase_high_o, 2); endproperty
  a_lo: assert property (p_lo) else $error("low part too short");
  property p_refuse; !div_ok |-> !step_busy_o; endproperty
  a_refuse: assert property (p_refuse) else $error("step taken on small ratio");
  property p_take; step_i.valid && !$past(step_i.valid) && !step_busy_o && div_ok |-> ##[1:3] step_busy_o;
  endproperty
  a_take: assert property (p_take) else $error("step not taken");
  property p_end; $rose(step_busy_o) |-> ##[1:300] !step_busy_o; endproperty
  a_end: assert property (p_end) else $error("step never applied");
endmodule : ops_shaper_chk
bind ops_shaper ops_shaper_chk #(.NUM_BUF(NUM_BUF)) i_chk (.core_clk_i, .reset_n_i, .clk_en_i, .cfg_i,
  .step_i, .step_busy_o, .phase_high_o, .true_output_pin_o, .complementary_output_pin_o);

//--- ops_rx_model.sv
// Pin receiver that measures high and low times of each period
`timescale 1ns/100ps
module ops_rx_model
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic rpt_o,
  output logic [31:0] hi_o,
  output logic [31:0] lo_o
);
  logic [31:0] hi_ff, lo_ff;
  logic pin_ff, seen_ff;
  // Rise to rise is one period, high part first
  always_ff @(posedge core_clk_i)
  begin
    pin_ff <= pin_i;
    rpt_o <= 1'b0;
    if (!reset_n_i)
      seen_ff <= 1'b0;
    else if (pin_i && !pin_ff)
    begin
      rpt_o <= seen_ff;
      seen_ff <= 1'b1;
      hi_o <= hi_ff;
      lo_o <= lo_ff;
      hi_ff <= 32'h0000_0001;
      lo_ff <= 32'h0000_0000;
    end
    else if (pin_i)
      hi_ff <= hi_ff + 32'h0000_0001;
    else
      lo_ff <= lo_ff + 32'h0000_0001;
  end
endmodule : ops_rx_model

//--- testbench.sv
// Testbench for the output pulse shaper
`timescale 1ns/100ps
module testbench
  import ops_pkg::*;
();
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en = 1'b1;
  ops_cfg_t cfg_i = '0;
  ops_step_t step_i = '0;
  logic busy, ph, rpt;
  logic [1:0] tp, cp;
  logic [31:0] hi, lo;
  int err_total = 0, n_compared = 0, cyc = 0;
  initial forever #5 core_clk_i = ~core_clk_i;
  ops_shaper #(.NUM_BUF(2)) i_dut (.core_clk_i, .reset_n_i, .clk_en_i(clk_en), .cfg_i, .step_i,
    .step_busy_o(busy), .phase_high_o(ph), .true_output_pin_o(tp), .complementary_output_pin_o(cp));
  ops_rx_model i_rx (.core_clk_i, .reset_n_i, .pin_i(tp[1]), .rpt_o(rpt), .hi_o(hi), .lo_o(lo));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic period(input int h, input int l);
    logic [1:0] cx;
    do @(posedge core_clk_i); while (rpt !== 1'b1);
    cx = tp ^ {2{cfg_i.diff_mode | cfg_i.comp_invert}};
    check(hi, h);
    check(lo, l);
    check(cp, cx);
  endtask : period
  task automatic run(input int d, input int w, input int s);
    int h, l, dh, dl;
    logic tk;
    logic [5:0] snap;
    h = (w == 0) ? ((d < 2) ? 1 : d / 2) : w;
    l = d - h;
    tk = (d >= 5);
    dh = (w == 0) ? s >>> 1 : 0;
    dl = s - dh;
    reset_n_i <= 1'b0;
    cfg_i <= '{32'(d), 32'(w), 1'($urandom), 1'($urandom)};
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    period(h, l);
    step_i <= '{1'b1, 33'(s)};
    repeat (2) @(posedge core_clk_i);
    step_i.valid <= 1'b0;
    period(h, l);
    period(tk ? ((h + dh < 2) ? 2 : h + dh) : h, tk ? ((l + dl < 2) ? 2 : l + dl) : l);
    period(h, l);
    clk_en <= 1'b0;
    @(posedge core_clk_i);
    snap = {tp, cp, busy, ph};
    repeat (d + 2) @(posedge core_clk_i);
    check({tp, cp, busy, ph}, snap);
    clk_en <= 1'b1;
  endtask : run
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    int d;
    void'($urandom(68));
    repeat (20) @(posedge core_clk_i);
    run(2, 0, 1);
    run(3, 1, -1);
    run(4, 0, 3);
    for (int i = 0; i < 14; i++)
    begin
      d = 6 + $urandom % 30;
      run(d, (i % 2) ? 0 : 2 + $urandom % (d - 3), int'($urandom % (2 * d)) - d);
    end
    finish_test();
  end
endmodule : testbench
